/* File: hw/ledp_pkg.sv */
// shared constants for the led dimming pwm timing core
`default_nettype none
package ledp_pkg;
  localparam int unsigned CLK_MHZ            = 125;
  localparam int unsigned CODE_W             = 7;
  localparam int unsigned CODE_CNT           = 128;
  // adc span 0.5v..1.5v, one code about 7.8mv, in microvolts
  localparam int unsigned ADC_LO_UV          = 500_000;
  localparam int unsigned ADC_HI_UV          = 1_500_000;
  localparam int unsigned ADC_STEP_UV        = 7_800;
  localparam int unsigned DIM_DIV            = 1000;
  localparam int unsigned DUTY_W             = 10;
  localparam int unsigned START_PCT          = 20;
  localparam int unsigned STEP_PERIODS       = 256;
  localparam int unsigned SS_MOD_HZ          = 3000;
  localparam int unsigned SS_MAX_PCT         = 125;
  localparam int unsigned SS_STEPS           = 16;
  localparam int unsigned SS_HOLD            = 2;
  // minimum off time per switching cycle, in ns
  localparam int unsigned MIN_OFF_NS         = 80;
  localparam int unsigned MIN_OFF_CYC        = (MIN_OFF_NS * CLK_MHZ) / 1000;
  localparam int unsigned SS_PHASES          = 2 * (SS_STEPS + SS_HOLD);
  localparam int unsigned SS_PHASE_CYC       = (CLK_MHZ * 1_000_000) / (SS_MOD_HZ * SS_PHASES);
endpackage : ledp_pkg
`default_nettype wire

/* File: hw/ledp_duty_rom.sv */
// exponential duty lookup table with registered read data
`default_nettype none
module ledp_duty_rom
  import ledp_pkg::*;
#(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 10
)
(
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  input  wire logic [AW-1:0] addr_i,
  output var  logic [DW-1:0] data_o
);
  logic [DW-1:0] rom [2**AW];

  // duty(k) = 1000 * 2^((k-127)*7/127): 0.78% .. 100%, exponentially spaced
  initial
  begin
    for (int k = 0; k < 2**AW; k++)
    begin
      rom[k] = DW'($rtoi(1000.0 * (2.0 ** ((real'(k) - 127.0) * 7.0 / 127.0)) + 0.5));
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      data_o <= '0;
    else
      data_o <= rom[addr_i];
  end
endmodule : ledp_duty_rom
`default_nettype wire

/* File: hw/ledp_core.sv */
// timing core: dimming, start-up step-up, spread spectrum, switch gate
`default_nettype none
// Notes on behaviour
// RL1: analog dimming level quantised to 7 bits
// RL2: each code selects exponentially spaced duty
// RL3: 0.5V to 1.5V spans all codes
// RL4: dimming clock is switching clock over 1000
// RL5: external low halts converter, opens load
// RL6: off interval stops pulses, compensation high-z
// RL7: steady high runs, steady low idles
// RL8: short external on intervals are honoured
// RL9: host avoids low glitches under 0.3us
// RL10: restart at 20%, step up over 256 periods
// RL11: spread spectrum always on, stepped triangle
// RL12: about 3kHz, sweep 100% to 125%
// RL13: forced minimum off time every cycle
// RL14: cycle start sets gate, comparator resets it
// RL15: one of 128 fixed duty values
// RL16: count dimming ticks, gate below threshold
module ledp_core
  import ledp_pkg::*;
#(
  parameter int unsigned NOM_PERIOD = 125,
  parameter int unsigned CODE_BITS  = 7
)
(
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 dim_pin_i,
  input  wire logic                 internal_mode_i,
  input  wire logic [15:0]          dim_level_mv_i,
  input  wire logic                 current_trip_i,
  input  wire logic                 restart_i,
  output var  logic                 switch_gate_o,
  output var  logic                 load_disconnect_gate_o,
  output var  logic                 comp_hiz_o,
  output var  logic [CODE_BITS-1:0] dim_code_o
);
  localparam int unsigned PW = 16;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [1:0] dim_sync_q;
  logic [1:0] trip_sync_q;
  logic [1:0] rst_sync_q;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dim_sync_q  <= 2'h0;
      trip_sync_q <= 2'h0;
      rst_sync_q  <= 2'h0;
    end
    else
    begin
      dim_sync_q  <= {dim_sync_q[0], dim_pin_i};
      trip_sync_q <= {trip_sync_q[0], current_trip_i};
      rst_sync_q  <= {rst_sync_q[0], restart_i};
    end
  end

  logic dim_pin_s;
  logic trip_s;
  logic restart_s;
  assign dim_pin_s = dim_sync_q[1];
  assign trip_s    = trip_sync_q[1];
  assign restart_s = rst_sync_q[1];

  // ****************************************
  // quantiser
  // ****************************************
  function automatic logic [CODE_BITS-1:0] quantise(input logic [15:0] mv);
    int unsigned uv;
    int unsigned c;
    uv = int'(mv) * 1000;
    if (uv <= ADC_LO_UV)
      c = 0;
    else if (uv >= ADC_HI_UV)
      c = CODE_CNT - 1;
    else
      c = (uv - ADC_LO_UV) / ADC_STEP_UV;
    if (c > CODE_CNT - 1)
      c = CODE_CNT - 1;
    return CODE_BITS'(c);
  endfunction : quantise

  logic [CODE_BITS-1:0] code_q;

  // RL1: linear code sampling
  // RL3: span clamp 0.5..1.5
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      code_q <= '0;
    else
      code_q <= quantise(dim_level_mv_i);
  end
  assign dim_code_o = code_q;

  // ****************************************
  // start-up step-up and spread spectrum
  // ****************************************
  logic [8:0]  stepup_q;
  logic [PW-1:0] per_cnt_q;
  logic [PW-1:0] period_lim;
  logic [4:0]  ss_step_q;
  logic        ss_up_q;
  logic [1:0]  ss_hold_q;
  logic [31:0] ss_tmr_q;
  logic        cyc_start;

  // RL10: slow period, ramp over 256 cycles
  // RL12: period shortens up to 125% frequency
  always_comb
  begin
    int unsigned slow;
    int unsigned base;
    slow = NOM_PERIOD * 100 / START_PCT;
    base = slow - ((slow - NOM_PERIOD) * int'(stepup_q)) / STEP_PERIODS;
    base = base - (base - base * 100 / SS_MAX_PCT) * int'(ss_step_q) / SS_STEPS;
    period_lim = PW'(base);
  end

  assign cyc_start = (per_cnt_q >= period_lim - PW'(1));

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      per_cnt_q <= '0;
    else if (cyc_start)
      per_cnt_q <= '0;
    else
      per_cnt_q <= per_cnt_q + PW'(1);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      stepup_q <= '0;
    else if (restart_s)
      stepup_q <= '0;
    else if (cyc_start && stepup_q != 9'(STEP_PERIODS))
      stepup_q <= stepup_q + 9'h001;
  end

  // RL11: stepped triangle, holds at peaks
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ss_tmr_q  <= '0;
      ss_step_q <= '0;
      ss_up_q   <= 1'b1;
      ss_hold_q <= '0;
    end
    else if (ss_tmr_q >= 32'(SS_PHASE_CYC - 1))
    begin
      ss_tmr_q <= '0;
      if (ss_hold_q != 2'h0)
        ss_hold_q <= ss_hold_q - 2'h1;
      else if (ss_up_q && ss_step_q == 5'(SS_STEPS))
      begin
        ss_up_q   <= 1'b0;
        ss_hold_q <= 2'(SS_HOLD);
      end
      else if (!ss_up_q && ss_step_q == 5'h00)
      begin
        ss_up_q   <= 1'b1;
        ss_hold_q <= 2'(SS_HOLD);
      end
      else if (ss_up_q)
        ss_step_q <= ss_step_q + 5'h01;
      else
        ss_step_q <= ss_step_q - 5'h01;
    end
    else
      ss_tmr_q <= ss_tmr_q + 32'h0000_0001;
  end

  // ****************************************
  // internal dimming generator
  // ****************************************
  logic [9:0]        div_cnt_q;
  logic [DUTY_W-1:0] dim_cnt_q;
  logic [DUTY_W-1:0] duty_thr;
  logic              dim_tick;
  logic              int_on_q;

  // RL4: one dimming tick per 1000 cycles
  assign dim_tick = cyc_start && (div_cnt_q == 10'(DIM_DIV - 1));

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_cnt_q <= '0;
    else if (dim_tick)
      div_cnt_q <= '0;
    else if (cyc_start)
      div_cnt_q <= div_cnt_q + 10'h001;
  end

  // RL15: table of 128 duties
  // RL2: exponential duty per code
  ledp_duty_rom #(
    .AW (CODE_BITS),
    .DW (DUTY_W)
  ) u_rom (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .addr_i    (code_q),
    .data_o    (duty_thr)
  );

  // RL16: tick counter against threshold
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      dim_cnt_q <= '0;
    else if (dim_tick)
      dim_cnt_q <= (dim_cnt_q == DUTY_W'(DIM_DIV - 1)) ? '0 : dim_cnt_q + DUTY_W'(1);
  end

  // compared every cycle: no wait of a whole tick after reset or a code change
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      int_on_q <= 1'b0;
    else
      int_on_q <= (dim_cnt_q < duty_thr);
  end

  // ****************************************
  // run gating and switch latch
  // ****************************************
  logic run;
  logic gate_q;
  logic [7:0] off_cnt_q;

  // RL5: external level gates run
  // RL7: steady levels give steady states
  // RL8: no filtering of short on pulses
  assign run = internal_mode_i ? int_on_q : dim_pin_s;

  // RL6: off interval, no pulses, high-z
  assign comp_hiz_o             = !run;
  assign load_disconnect_gate_o = run;

  // RL13: forced off at end of cycle
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      off_cnt_q <= '0;
    else
      off_cnt_q <= 8'(MIN_OFF_CYC);
  end

  // RL14: set on start, reset on trip
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      gate_q <= 1'b0;
    else if (!run || trip_s || restart_s)
      gate_q <= 1'b0;
    else if ((period_lim - per_cnt_q) <= PW'(off_cnt_q) + PW'(1))
      gate_q <= 1'b0;
    else if (per_cnt_q == '0)
      gate_q <= 1'b1;
  end
  assign switch_gate_o = gate_q;
endmodule : ledp_core
`default_nettype wire

/* File: sim/ledp_host_model.sv */
// host model: steady level or pwm on the dimming pin
`default_nettype none
module ledp_host_model
(
  input  wire logic        mclk_i,
  input  wire logic        pwm_en_i,
  input  wire logic        level_i,
  input  wire logic [15:0] on_len_i,
  input  wire logic [15:0] off_len_i,
  output var  logic        dim_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q = 16'h0000;
  logic [15:0] off_c;
  initial dim_pin_o = 1'b0;
  assign off_c = (off_len_i < 16'h0026) ? 16'h0026 : off_len_i;
  always @(posedge mclk_i)
  begin
    cnt_q <= cnt_q + 16'h0001;
    if (!pwm_en_i)
    begin
      dim_pin_o <= level_i;
      cnt_q     <= 16'h0000;
    end
    else if (cnt_q == (dim_pin_o ? on_len_i : off_c) - 16'h0001)
    begin
      dim_pin_o <= !dim_pin_o;
      cnt_q     <= 16'h0000;
    end
  end
endmodule : ledp_host_model
`default_nettype wire

/* File: sim/ledp_core_properties.sv */
// concurrent checks on the timing core ports
`default_nettype none
module ledp_core_properties
  import ledp_pkg::*;
#(
  parameter int unsigned NOM_PERIOD = 125,
  parameter int unsigned CODE_BITS  = 7
)
(
  input wire logic                 mclk_i,
  input wire logic                 reset_n_i,
  input wire logic                 dim_pin_i,
  input wire logic                 internal_mode_i,
  input wire logic [15:0]          dim_level_mv_i,
  input wire logic                 current_trip_i,
  input wire logic                 restart_i,
  input wire logic                 switch_gate_o,
  input wire logic                 load_disconnect_gate_o,
  input wire logic                 comp_hiz_o,
  input wire logic [CODE_BITS-1:0] dim_code_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic [15:0] lo_q;
  // low cycles before each gate rise
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lo_q <= 16'hFFFF;
    else if (switch_gate_o)
      lo_q <= 16'h0000;
    else if (lo_q != 16'hFFFF)
      lo_q <= lo_q + 16'h0001;
  end
  sequence s_ext;
    (!internal_mode_i)[*3] ##0 $past(reset_n_i, 2);
  endsequence
  property p_load_follow;
    s_ext |-> load_disconnect_gate_o == $past(dim_pin_i, 2);
  endproperty
  property p_hiz;
    comp_hiz_o != load_disconnect_gate_o;
  endproperty
  property p_off_quiet;
    (!load_disconnect_gate_o)[*2] |-> !switch_gate_o;
  endproperty
  property p_trip;
    current_trip_i[*4] |-> !switch_gate_o;
  endproperty
  property p_min_off;
    $rose(switch_gate_o) |-> lo_q >= MIN_OFF_CYC;
  endproperty
  property p_code_lo;
    (internal_mode_i && dim_level_mv_i < 16'h01F4)[*3] |-> dim_code_o == 0;
  endproperty
  property p_code_hi;
    (internal_mode_i && dim_level_mv_i >= 16'h05DC)[*3] |-> dim_code_o == 7'h7F;
  endproperty
  property p_idle;
    (!internal_mode_i && !dim_pin_i)[*4] |-> comp_hiz_o && !switch_gate_o;
  endproperty
  a_load_follow: assert property (p_load_follow)
    else $error("load gate not following pin");
  a_hiz: assert property (p_hiz)
    else $error("comp hiz not inverse of run");
  a_off_quiet: assert property (p_off_quiet)
    else $error("switching during off interval");
  a_trip: assert property (p_trip)
    else $error("gate on while trip held");
  a_min_off: assert property (p_min_off)
    else $error("off time too short");
  a_code_lo: assert property (p_code_lo)
    else $error("code not zero below span");
  a_code_hi: assert property (p_code_hi)
    else $error("code not full above span");
  a_idle: assert property (p_idle)
    else $error("not idle with pin low");
endmodule : ledp_core_properties
bind ledp_core ledp_core_properties #(.NOM_PERIOD(NOM_PERIOD), .CODE_BITS(CODE_BITS))
  i_ledp_core_properties (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .dim_pin_i(dim_pin_i),
  .internal_mode_i(internal_mode_i), .dim_level_mv_i(dim_level_mv_i),
  .current_trip_i(current_trip_i), .restart_i(restart_i), .switch_gate_o(switch_gate_o),
  .load_disconnect_gate_o(load_disconnect_gate_o), .comp_hiz_o(comp_hiz_o),
  .dim_code_o(dim_code_o));
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the dimming timing core
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NOM = 20;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, internal_mode_i = 1'b0;
  logic current_trip_i = 1'b0, restart_i = 1'b0, pwm_en = 1'b0, lvl = 1'b0;
  logic [15:0] dim_level_mv_i = 16'h0000;
  logic dim_pin_i, switch_gate_o, load_disconnect_gate_o, comp_hiz_o, sw_q;
  logic [6:0] dim_code_o;
  int cnt, gap, gmin, gmax, lw, wid, lows, rs, nrise, cyc, fails, num_checks;
  int duty_seen [7];
  // level in mv beside expected code
  logic [22:0] rows [7] = '{{16'h0000, 7'h00}, {16'h01F4, 7'h00}, {16'h01FC, 7'h01},
    {16'h03E8, 7'h40}, {16'h05D2, 7'h7E}, {16'h05DC, 7'h7F}, {16'h07D0, 7'h7F}};
  initial forever #4 mclk_i = ~mclk_i;
  ledp_host_model i_ledp_host_model (.mclk_i(mclk_i), .pwm_en_i(pwm_en), .level_i(lvl),
    .on_len_i(16'h0032), .off_len_i(16'h00C8), .dim_pin_o(dim_pin_i));
  ledp_core #(.NOM_PERIOD(NOM), .CODE_BITS(7)) i_ledp_core (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .dim_pin_i(dim_pin_i), .internal_mode_i(internal_mode_i),
    .dim_level_mv_i(dim_level_mv_i), .current_trip_i(current_trip_i),
    .restart_i(restart_i), .switch_gate_o(switch_gate_o),
    .load_disconnect_gate_o(load_disconnect_gate_o), .comp_hiz_o(comp_hiz_o),
    .dim_code_o(dim_code_o));
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic watch(input int n);
    int r0;
    r0 = nrise;
    lows = 0;
    repeat (n)
    begin
      @(posedge mclk_i);
      lows += (load_disconnect_gate_o !== 1'b1);
    end
    rs = nrise - r0;
  endtask : watch
  // gate periods, load pulse width, timeout
  always @(posedge mclk_i)
  begin
    cyc++;
    cnt++;
    if (load_disconnect_gate_o === 1'b1)
      lw++;
    else
    begin
      if (lw > 0)
        wid = lw;
      lw = 0;
    end
    if (switch_gate_o === 1'b1 && sw_q !== 1'b1)
    begin
      gap = cnt;
      cnt = 0;
      nrise++;
      gmin = (gap < gmin) ? gap : gmin;
      gmax = (gap > gmax) ? gap : gmax;
    end
    sw_q = switch_gate_o;
    if (cyc == 90000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk_i);
    chk("hiz_rst", 16'h0001, 16'(comp_hiz_o));
    chk("out_rst", 16'h0000, 16'({switch_gate_o, load_disconnect_gate_o, dim_code_o}));
    reset_n_i <= 1'b1;
    internal_mode_i <= 1'b1;
    $display("test reset done");
    foreach (rows[i])
    begin
      dim_level_mv_i <= rows[i][22:7];
      repeat (4) @(posedge mclk_i);
      chk("code", 16'(rows[i][6:0]), 16'(dim_code_o));
      duty_seen[i] = int'(i_ledp_core.duty_thr);
    end
    chk("duty_full", 16'(ledp_pkg::DIM_DIV), 16'(duty_seen[6]));
    chk("duty_exp", 16'h0001, 16'(duty_seen[3] < 250 &&
      duty_seen[5] - duty_seen[4] > duty_seen[2] - duty_seen[1]));
    watch(2000);
    chk("full_duty", 16'h0000, 16'(lows));
    $display("test internal done");
    internal_mode_i <= 1'b0;
    lvl <= 1'b1;
    repeat (50) @(posedge mclk_i);
    watch(400);
    chk("run_load", 16'h0000, 16'(lows));
    chk("run_sw", 16'h0001, 16'(rs > 0));
    lvl <= 1'b0;
    repeat (5) @(posedge mclk_i);
    watch(400);
    chk("idle_sw", 16'h0000, 16'(rs));
    chk("idle_hiz", 16'h0001, 16'(comp_hiz_o));
    $display("test external done");
    lvl <= 1'b1;
    current_trip_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    watch(300);
    chk("trip_sw", 16'h0000, 16'(rs));
    current_trip_i <= 1'b0;
    watch(300);
    chk("trip_end", 16'h0001, 16'(rs > 0));
    pwm_en <= 1'b1;
    watch(600);
    chk("short_on", 16'h0032, 16'(wid));
    pwm_en <= 1'b0;
    $display("test trip and pulse done");
    repeat (20000) @(posedge mclk_i);
    gmin = 100000;
    gmax = 0;
    repeat (42000) @(posedge mclk_i);
    chk("ss_min", 16'h0001, 16'(gmin >= NOM*4/5 - 1 && gmin <= NOM*4/5 + 1));
    chk("ss_max", 16'h0001, 16'(gmax >= NOM - 1 && gmax <= NOM + 1));
    restart_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    restart_i <= 1'b0;
    repeat (300) @(posedge mclk_i);
    chk("slow_start", 16'h0001, 16'(gap >= 3 * NOM));
    repeat (18000) @(posedge mclk_i);
    chk("step_up", 16'h0001, 16'(gap <= NOM + 1));
    $display("test frequency done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
